// ===== include/thg_pkg.sv
package thg_pkg;
  // word and test window sizes
  localparam int WORD_W = 16;
  localparam int WIN_BITS = 256;
  localparam int ONES_MIN = 96;
  localparam int ONES_MAX = 160;
  localparam int REP_LIMIT = 32;
  localparam int FIFO_DEPTH = 2;
  // values after reset
  localparam logic RST_FLAG = 1'h0;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_TEST = 2'b01,
    ST_RUN  = 2'b10,
    ST_FAIL = 2'b11
  } thg_state_t;
endpackage

// ===== include/thg_if.sv
`timescale 1ns/100ps
// word path from the health gate into the two-entry buffer and out again
interface thg_if #(parameter int WIDTH = 16) ();
  logic inValid;
  logic inReady;
  logic [WIDTH-1:0] inData;
  logic outValid;
  logic outReady;
  logic [WIDTH-1:0] outData;
  logic flush;

  modport feed (output inValid, input inReady, output inData,
                input outValid, output outReady, input outData, output flush);
  modport store (input inValid, output inReady, input inData,
                 output outValid, input outReady, output outData, input flush);
endinterface

// ===== design/thg_fifo2.sv
`timescale 1ns/100ps
// two-entry buffer; a stalled reader fills it and then holds off the writer
module thg_fifo2 #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 2
) (
  input wire logic clk,
  input wire logic rst_n,
  thg_if.store port
);
  import thg_pkg::*;

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wrPtr;
  logic [PW-1:0] rdPtr;
  logic [PW:0] count;

  // handshake decode
  wire doWrite = port.inValid && port.inReady;
  wire doRead = port.outValid && port.outReady;
  assign port.inReady = (count != (PW+1)'(DEPTH)) && !port.flush;
  assign port.outValid = (count != '0) && !port.flush;
  assign port.outData = mem[rdPtr];

  // pointer wrap, used by both pointers
  function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
    bump = (p == PW'(DEPTH - 1)) ? '0 : PW'(p + 1'b1);
  endfunction

  // pointers and fill level; flush drops whatever is held
  always_ff @(posedge clk) begin
    if (!rst_n || port.flush) begin
      wrPtr <= '0;
      rdPtr <= '0;
      count <= '0;
    end else begin
      if (doWrite) wrPtr <= bump(wrPtr);
      if (doRead) rdPtr <= bump(rdPtr);
      count <= count + (PW+1)'(doWrite) - (PW+1)'(doRead);
    end
  end

  // storage needs no reset; it is never read while empty
  always_ff @(posedge clk) begin
    if (doWrite) mem[wrPtr] <= port.inData;
  end
endmodule

// ===== design/thg_gate.sv
`timescale 1ns/100ps
// How it works
// - start-up runs stuck-source check before use
// - after total failure, no words delivered
// - failure in operation flushes pending words
// - ones-count window test at start and always
// - no output until start-up window passes
// - bad window stops output at once
// - every window ends within fixed bit count
// - each delivered number is sixteen bits
// - test request reruns the gating test window
// - done and pass flags report test result
// - any failure raises error, stops source
module thg_gate #(
  parameter int WIN = thg_pkg::WIN_BITS,
  parameter int ONES_LO = thg_pkg::ONES_MIN,
  parameter int ONES_HI = thg_pkg::ONES_MAX,
  parameter int REP = thg_pkg::REP_LIMIT
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic genStart,
  input wire logic testReq,
  input wire logic rawBit,
  input wire logic rawValid,
  output logic rawReady,
  input wire logic numReady,
  output logic [thg_pkg::WORD_W-1:0] numData,
  output logic numValid,
  output logic srcEnable,
  output logic testDone,
  output logic testPass,
  output logic errTotal,
  output logic errDefect
);
  import thg_pkg::*;

  localparam int BW = $clog2(WIN);
  localparam int OW = $clog2(WIN + 1);
  localparam int RW = $clog2(REP + 1);
  localparam int CW = $clog2(WORD_W);

  thg_state_t state;
  thg_state_t next_state;
  logic lastBit;
  logic [RW-1:0] runLen;
  logic [BW-1:0] bitCnt;
  logic [OW-1:0] onesCnt;
  logic [WORD_W-1:0] shiftWord;
  logic [CW-1:0] wordCnt;
  logic wordFull;

  thg_if #(.WIDTH(WORD_W)) link ();

  thg_fifo2 #(.WIDTH(WORD_W), .DEPTH(FIFO_DEPTH)) u_buf (
    .clk(clk),
    .rst_n(rst_n),
    .port(link.store)
  );

  // window verdict, used by the state logic and by the checks
  function automatic logic windowBad(input logic [OW-1:0] ones);
    windowBad = (ones < OW'(ONES_LO)) || (ones > OW'(ONES_HI));
  endfunction

  // raw bits are taken only while running and no finished word waits
  wire running = (state == ST_TEST) || (state == ST_RUN);
  assign rawReady = running && !wordFull;
  wire takeBit = rawValid && rawReady;
  wire repHit = takeBit && (runLen != '0) && (rawBit == lastBit)
                && (runLen == RW'(REP - 1));
  wire winEnd = takeBit && (bitCnt == BW'(WIN - 1));
  wire [OW-1:0] onesNow = onesCnt + OW'(rawBit);
  wire winFail = winEnd && windowBad(onesNow);
  wire enterTest = (next_state == ST_TEST) && (state != ST_TEST);
  wire wordDone = takeBit && (state == ST_RUN) && (wordCnt == CW'(WORD_W - 1));

  // state transitions; failure outranks every other event
  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (genStart) next_state = ST_TEST;
      end
      ST_TEST, ST_RUN: begin
        if (repHit || winFail) next_state = ST_FAIL;
        else if (!genStart) next_state = ST_IDLE;
        else if (state == ST_TEST && winEnd) next_state = ST_RUN;
        else if (state == ST_RUN && testReq) next_state = ST_TEST;
      end
      ST_FAIL: begin
        // shut down until software drops the start request
        if (!genStart) next_state = ST_IDLE;
      end
      default: next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) state <= ST_IDLE;
    else state <= next_state;
  end

  // run length of identical bits, restarted with each test
  always_ff @(posedge clk) begin
    if (!rst_n || enterTest) begin
      runLen <= '0;
      lastBit <= RST_FLAG;
    end else if (takeBit) begin
      lastBit <= rawBit;
      runLen <= (rawBit == lastBit && runLen != '0) ? RW'(runLen + 1'b1) : RW'(1);
    end
  end

  // ones count over back-to-back windows, never idle while running
  always_ff @(posedge clk) begin
    if (!rst_n || enterTest) begin
      bitCnt <= '0;
      onesCnt <= '0;
    end else if (winEnd) begin
      bitCnt <= '0;
      onesCnt <= '0;
    end else if (takeBit) begin
      bitCnt <= BW'(bitCnt + 1'b1);
      onesCnt <= onesNow;
    end
  end

  // sixteen raw bits make one word; only assembled in ST_RUN, not during a test
  always_ff @(posedge clk) begin
    if (!rst_n || state != ST_RUN) begin
      shiftWord <= '0;
      wordCnt <= '0;
      wordFull <= 1'b0;
    end else begin
      if (takeBit) begin
        shiftWord <= {shiftWord[WORD_W-2:0], rawBit};
        wordCnt <= CW'(wordCnt + 1'b1);
      end
      if (wordDone) wordFull <= 1'b1;
      else if (link.inReady) wordFull <= 1'b0;
    end
  end

  // a word that would complete on the failing bit is never pushed
  assign link.inValid = wordFull && (state == ST_RUN);
  assign link.inData = shiftWord;
  // anything buffered is discarded once output is gated
  assign link.flush = (state != ST_RUN);
  assign link.outReady = numReady && (state == ST_RUN);

  // valid only in the passed, running state
  assign numValid = link.outValid && (state == ST_RUN);
  assign numData = link.outData;
  // source runs only while testing or delivering
  assign srcEnable = running;

  // status flags; a start clears them, hardware events set them
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      testDone <= RST_FLAG;
      testPass <= RST_FLAG;
      errTotal <= RST_FLAG;
      errDefect <= RST_FLAG;
    end else begin
      if (repHit) errTotal <= 1'b1;
      else if (enterTest && state == ST_IDLE) errTotal <= 1'b0;
      if (winFail) errDefect <= 1'b1;
      else if (enterTest && state == ST_IDLE) errDefect <= 1'b0;
      if (repHit || (state == ST_TEST && winEnd)) testDone <= 1'b1;
      else if (enterTest) testDone <= 1'b0;
      if (state == ST_TEST && winEnd && !repHit && !winFail) testPass <= 1'b1;
      else if (enterTest || repHit || winFail) testPass <= 1'b0;
    end
  end

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_windowFails;
    state == ST_TEST && winFail;
  endsequence
  sequence s_gatedAfter;
    state == ST_FAIL && !numValid && !srcEnable;
  endsequence

  AST_START_TESTS: assert property (
    state == ST_IDLE && genStart |=> state == ST_TEST && srcEnable && !numValid)
    else $error("start did not enter the test state");
  AST_FAIL_SILENT: assert property (
    state == ST_FAIL |-> !numValid ##1 (state != ST_FAIL || !numValid))
    else $error("output seen after total failure");
  AST_STUCK_FLUSH: assert property (
    repHit |=> s_gatedAfter and errTotal && !link.outValid)
    else $error("stuck source did not flush and gate");
  AST_WINDOW_RESTART: assert property (
    running && winEnd && !repHit && !winFail && genStart |=> bitCnt == '0 && onesCnt == '0)
    else $error("test window not restarted");
  AST_NO_EARLY_OUT: assert property (
    !testPass |-> !numValid)
    else $error("output before start-up test passed");
  AST_DEFECT_STOP: assert property (
    winFail |=> errDefect && !numValid && state == ST_FAIL)
    else $error("defect did not stop output");
  // bits since last verdict; kept apart from the window counter so a
  // broken window end shows up instead of wrapping silently
  logic [15:0] sinceVerdict;
  always_ff @(posedge clk) begin
    if (!rst_n || enterTest || winEnd) sinceVerdict <= '0;
    else if (takeBit) sinceVerdict <= sinceVerdict + 16'h1;
  end

  AST_WINDOW_BOUND: assert property (
    running |-> sinceVerdict < 16'(WIN))
    else $error("window counter ran past its length");
  AST_WORD_PUSH: assert property (
    wordDone |=> wordFull && wordCnt == '0 && link.inData[0] == $past(rawBit))
    else $error("word not assembled from sixteen bits");
  AST_REQ_RETEST: assert property (
    state == ST_RUN && testReq && !repHit && !winFail && genStart
    |=> state == ST_TEST && !testDone && !numValid)
    else $error("test request did not rerun the test");
  AST_REPORT_PASS: assert property (
    state == ST_TEST && winEnd && !winFail && !repHit |=> testDone && testPass)
    else $error("passing test not reported");
  AST_SHUTDOWN: assert property (
    s_windowFails |=> s_gatedAfter ##0 errDefect && testDone && !testPass)
    else $error("failing test did not shut down");
  AST_VALID_GATE: assert property (
    numValid |-> state == ST_RUN && testPass && !errTotal && !errDefect)
    else $error("valid raised while gated");
endmodule

// ===== tb/thg_consumer.sv
`timescale 1ns/100ps
// word consumer standing in for software; stall holds off every read
module thg_consumer
  import thg_pkg::*;
(
  input wire logic clk,
  input wire logic stall,
  input wire logic numValid,
  input wire logic [thg_pkg::WORD_W-1:0] numData,
  output logic numReady
);
  logic [WORD_W-1:0] words[$];
  // a stalled reader lets the buffer fill up
  assign numReady = !stall;
  // record on the rising edge that completes the handshake; stall moves at the
  // falling edge, so sampling there would race the bench driving it
  always @(posedge clk) begin
    if (numValid && numReady) begin
      words.push_back(numData);
    end
  end
endmodule

// ===== tb/testbench.sv
`timescale 1ns/100ps
module testbench;
  import thg_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic genStart = 1'b0;
  logic testReq = 1'b0;
  logic rawBit = 1'b0;
  logic rawValid = 1'b0;
  logic stall = 1'b0;
  logic rawReady, numReady, numValid, srcEnable, testDone, testPass, errTotal, errDefect;
  logic [WORD_W-1:0] numData;
  int bad_count = 0;
  int cmp_count = 0;
  // status in one vector: src, done, pass, total, defect, valid
  wire logic [5:0] flags = {srcEnable, testDone, testPass, errTotal, errDefect, numValid};
  // 10 MHz clock
  always #50 clk = ~clk;
  // short windows keep the run brief
  thg_gate #(.WIN(16), .ONES_LO(4), .ONES_HI(12), .REP(6)) i_dut (.clk(clk), .rst_n(rst_n),
    .genStart(genStart), .testReq(testReq), .rawBit(rawBit), .rawValid(rawValid),
    .rawReady(rawReady), .numReady(numReady), .numData(numData), .numValid(numValid),
    .srcEnable(srcEnable), .testDone(testDone), .testPass(testPass), .errTotal(errTotal),
    .errDefect(errDefect));
  thg_consumer i_cons (.clk(clk), .stall(stall), .numValid(numValid), .numData(numData),
    .numReady(numReady));
  // compare and count
  task automatic check(input logic [WORD_W-1:0] seen, input logic [WORD_W-1:0] want,
      input string what);
    cmp_count++;
    if (seen !== want) begin
      bad_count++;
      $display("Error at %0t: %s seen %h want %h", $time, what, seen, want);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  // send the top n bits of w, msb first, holding each until taken, waiting at most 20 cycles for ready
  task automatic feed(input logic [WORD_W-1:0] w, input int n);
    for (int i = WORD_W - 1; i >= WORD_W - n; i--) begin
      rawBit = w[i];
      rawValid = 1'b1;
      for (int g = 0; g < 20 && !rawReady; g++) @(negedge clk);
      @(negedge clk);
    end
    rawValid = 1'b0;
    @(negedge clk);
  endtask
  task automatic testStart();
    check(flags, 6'b000000, "idle after reset");
    genStart = 1'b1;
    cyc(2);
    check(flags, 6'b100000, "start-up test running");
    check(rawReady, 1'b1, "raw bits accepted in test");
    feed(16'ha5a5, 16);
    check(i_cons.words.size(), 0, "no word before pass");
    check(flags, 6'b111000, "start-up pass reported");
    $display("start test finished");
  endtask
  task automatic testWords();
    stall = 1'b1;
    feed(16'ha5a5, 16);
    feed(16'h5a5a, 16);
    feed(16'ha5a5, 16);
    cyc(2);
    check(rawReady, 1'b0, "full buffer stalls raw bits");
    check(numValid, 1'b1, "words waiting");
    stall = 1'b0;
    cyc(6);
    check(i_cons.words.size(), 3, "word count");
    for (int k = 0; k < 3; k++) begin
      check(i_cons.words[k], k[0] ? 16'h5a5a : 16'ha5a5, "word value");
    end
    $display("word test finished");
  endtask
  task automatic testRequest();
    testReq = 1'b1;
    @(negedge clk);
    testReq = 1'b0;
    check(flags, 6'b100000, "request restarts test");
    feed(16'h5a5a, 16);
    check(flags, 6'b111000, "request window passes");
    $display("request test finished");
  endtask
  task automatic testDefect();
    i_cons.words.delete();
    // fourteen ones with no long run: a window defect only
    feed(16'hf7df, 15);
    check(flags, 6'b111000, "no verdict before window end");
    feed(16'hffff, 1);
    check(flags, 6'b010010, "defect stops output");
    check(rawReady, 1'b0, "source shut down");
    check(i_cons.words.size(), 0, "no word from bad window");
    genStart = 1'b0;
    cyc(2);
    genStart = 1'b1;
    cyc(2);
    check(flags, 6'b100000, "fresh start clears error");
    $display("defect test finished");
  endtask
  task automatic testStuck();
    feed(16'hffff, 6);
    check(flags, 6'b010100, "stuck source at start-up");
    genStart = 1'b0;
    cyc(2);
    genStart = 1'b1;
    cyc(2);
    feed(16'ha5a5, 16);
    stall = 1'b1;
    feed(16'h5a5a, 16);
    cyc(2);
    check(numValid, 1'b1, "word buffered");
    feed(16'hffff, 6);
    check(flags, 6'b010100, "stuck source in run");
    stall = 1'b0;
    cyc(4);
    check(i_cons.words.size(), 0, "buffered word flushed");
    genStart = 1'b0;
    cyc(2);
    genStart = 1'b1;
    cyc(2);
    feed(16'ha5a5, 16);
    check(flags, 6'b111000, "restart after stuck passes");
    check(numValid, 1'b0, "no stale word after restart");
    genStart = 1'b0;
    cyc(2);
    check(flags, 6'b011000, "status kept after stop");
    $display("stuck test finished");
  endtask
  task automatic results();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // main sequence
  initial begin
    cyc(12);
    rst_n = 1'b1;
    cyc(1);
    testStart();
    testWords();
    testRequest();
    testDefect();
    testStuck();
    results();
  end
  // watchdog: the tests need well under a thousand cycles
  initial begin
    #(100 * 20000);
    bad_count++;
    results();
  end
endmodule
